// file: pkg/trace_buffer_pkg.sv
package trace_buffer_pkg;
  localparam logic [31:0] REG_BASE_ADDR   = 32'h41006000;
  localparam logic [3:0]  OFS_POSITION    = 4'h0;
  localparam logic [3:0]  OFS_MAIN_CTRL   = 4'h4;
  localparam logic [3:0]  OFS_STOP_HALT   = 4'h8;
  localparam logic [3:0]  OFS_SRAM_LOC    = 4'hc;
  localparam int          POS_WRAP_BIT    = 2;
  localparam int          POS_PTR_LSB     = 3;
  localparam int          CTRL_ON_BIT     = 31;
  localparam int          CTRL_MASK_LSB   = 0;
  localparam int          CTRL_MASK_W     = 5;
  localparam int          FILL_STOP_BIT   = 0;
  localparam int          FILL_HALT_BIT   = 1;
  localparam int          FILL_ADDR_LSB   = 3;
  localparam logic [31:0] RESET_ZERO      = 32'h00000000;
  localparam logic [31:0] PC_STEP         = 32'h00000002;
  localparam logic [31:0] PC_STEP_WIDE    = 32'h00000004;
  localparam logic [31:0] WORD_BYTES      = 32'h00000004;
  localparam logic [31:0] SRAM_BASE_DFLT  = 32'h20000000;
  localparam logic [4:0]  MASK_BASE       = 5'h04;
  localparam logic [31:0] UNMAPPED_DATA   = 32'h00000000;
endpackage

// file: hdl/execution_trace_buffer.sv
`timescale 1ns/1ps
module execution_trace_buffer #(
  parameter int          SRAM_AW   = 12,
  parameter logic [31:0] SRAM_BASE = trace_buffer_pkg::SRAM_BASE_DFLT
) (
  input  wire logic               clock_i,
  input  wire logic               srst_i,
  // Avalon-MM register slave, byte address
  input  wire logic [31:0]        avs_address_i,
  input  wire logic               avs_read_i,
  input  wire logic               avs_write_i,
  input  wire logic [3:0]         avs_byteenable_i,
  input  wire logic [31:0]        avs_writedata_i,
  output logic      [31:0]        avs_readdata_o,
  output logic                    avs_waitrequest_o,
  // Core execution trace interface
  input  wire logic               trace_valid_i,
  input  wire logic [31:0]        trace_pc_i,
  input  wire logic               trace_branch_i,
  input  wire logic               trace_exception_i,
  // Processor SRAM port
  input  wire logic               cpu_req_i,
  input  wire logic               cpu_we_i,
  input  wire logic [SRAM_AW-1:0] cpu_addr_i,
  input  wire logic [31:0]        cpu_wdata_i,
  input  wire logic [3:0]         cpu_be_i,
  output logic                    cpu_gnt_o,
  output logic      [31:0]        cpu_rdata_o,
  // Shared SRAM port
  output logic                    sram_req_o,
  output logic                    sram_we_o,
  output logic      [SRAM_AW-1:0] sram_addr_o,
  output logic      [31:0]        sram_wdata_o,
  output logic      [3:0]         sram_be_o,
  input  wire logic [31:0]        sram_rdata_i,
  output logic                    debug_halt_o,
  output logic                    trace_on_o
);

  typedef enum logic [2:0] {
    PK_IDLE   = 3'b001,
    PK_FIRST  = 3'b010,
    PK_SECOND = 3'b100
  } pkt_state_t;

  localparam int PW = SRAM_AW - trace_buffer_pkg::POS_PTR_LSB;

  pkt_state_t        pkt_q;
  logic              on_q;
  logic              wrap_q;
  logic [PW-1:0]     ptr_q;
  logic [PW-1:0]     limit_q;
  logic              fill_stop_q;
  logic              fill_halt_q;
  logic [4:0]        mask_q;
  logic              halt_q;
  logic              resp_q;
  logic [31:0]       rdata_q;
  logic [31:0]       last_pc_q;
  logic              last_ok_q;
  logic [31:0]       src_q;
  logic [31:0]       dst_q;
  logic              seq_step;
  logic              nonseq;
  logic              trace_wr;
  logic              sel;
  logic [3:0]        ofs;
  logic              wr_on;
  logic              wr_pos;
  logic              wr_ctl;
  logic              wr_fill;
  logic [PW-1:0]     mask_ptr;
  logic [PW-1:0]     ptr_inc;
  logic [PW-1:0]     ptr_next;
  logic              wrap_now;
  logic              limit_hit;
  logic [31:0]       pos_word;
  logic [31:0]       ctl_word;
  logic [31:0]       fill_word;

  // Buffer size is 2^(mask+4) bytes; pointer bits above that stay fixed
  genvar gi;
  generate
    for (gi = 0; gi < PW; gi++) begin : g_mask
      assign mask_ptr[gi] = (32'(gi) + 32'd3) < (32'(mask_q) + 32'd4);
    end
  endgenerate

  assign sel = (avs_address_i[31:4] == trace_buffer_pkg::REG_BASE_ADDR[31:4]);
  assign ofs = avs_address_i[3:0];
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~resp_q;
  // Writes land on the answer edge only, so a stalled master never writes twice
  assign wr_pos  = avs_write_i & resp_q & sel & (ofs == trace_buffer_pkg::OFS_POSITION);
  assign wr_ctl  = avs_write_i & resp_q & sel & (ofs == trace_buffer_pkg::OFS_MAIN_CTRL);
  assign wr_fill = avs_write_i & resp_q & sel & (ofs == trace_buffer_pkg::OFS_STOP_HALT);
  assign wr_on   = wr_ctl & avs_byteenable_i[3];

  // Sequential means +2 or +4 with no branch or exception flag
  assign seq_step = (trace_pc_i == last_pc_q + trace_buffer_pkg::PC_STEP) ||
                    (trace_pc_i == last_pc_q + trace_buffer_pkg::PC_STEP_WIDE);
  assign nonseq = trace_valid_i & last_ok_q &
                  (trace_branch_i | trace_exception_i | ~seq_step);

  assign trace_wr = (pkt_q != PK_IDLE);
  assign ptr_inc  = ptr_q + PW'(1);
  // Only bits inside the buffer size advance; wrap when those all roll over
  assign ptr_next = (ptr_q & ~mask_ptr) | (ptr_inc & mask_ptr);
  assign wrap_now = ((ptr_q & mask_ptr) == mask_ptr);
  assign limit_hit = trace_wr && (pkt_q == PK_SECOND) && (ptr_next == limit_q);

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      last_pc_q <= trace_buffer_pkg::RESET_ZERO;
      last_ok_q <= 1'b0;
    end else if (trace_valid_i) begin
      last_pc_q <= trace_pc_i;
      last_ok_q <= 1'b1;
    end
  end

  // A new change arriving mid-packet is dropped; at most one packet per three cycles
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pkt_q <= PK_IDLE;
      src_q <= trace_buffer_pkg::RESET_ZERO;
      dst_q <= trace_buffer_pkg::RESET_ZERO;
    end else begin
      case (pkt_q)
        PK_IDLE: begin
          if (nonseq && on_q) begin
            src_q <= last_pc_q;
            dst_q <= trace_pc_i;
            pkt_q <= PK_FIRST;
          end
        end
        PK_FIRST:  pkt_q <= PK_SECOND;
        PK_SECOND: pkt_q <= PK_IDLE;
        default:   pkt_q <= PK_IDLE;
      endcase
    end
  end

  // Trace owns the SRAM port whenever a packet word is pending
  always_comb begin
    if (trace_wr) begin
      sram_req_o   = 1'b1;
      sram_we_o    = 1'b1;
      sram_addr_o  = {ptr_q, (pkt_q == PK_SECOND), 2'b00};
      sram_wdata_o = (pkt_q == PK_FIRST) ? src_q : dst_q;
      sram_be_o    = 4'hf;
      cpu_gnt_o    = 1'b0;
    end else begin
      sram_req_o   = cpu_req_i;
      sram_we_o    = cpu_we_i;
      sram_addr_o  = cpu_addr_i;
      sram_wdata_o = cpu_wdata_i;
      sram_be_o    = cpu_be_i;
      cpu_gnt_o    = cpu_req_i;
    end
  end
  assign cpu_rdata_o = sram_rdata_i;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ptr_q  <= '0;
      wrap_q <= 1'b0;
    end else if (wr_pos) begin
      ptr_q  <= avs_writedata_i[SRAM_AW-1:trace_buffer_pkg::POS_PTR_LSB];
      wrap_q <= avs_writedata_i[trace_buffer_pkg::POS_WRAP_BIT];
    end else if (pkt_q == PK_SECOND) begin
      ptr_q <= ptr_next;
      if (wrap_now) begin
        wrap_q <= 1'b1;
      end
    end
  end

  // The fill limit wins over a same-cycle software enable
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      on_q <= 1'b0;
    end else if (limit_hit && (fill_stop_q || fill_halt_q)) begin
      on_q <= 1'b0;
    end else if (wr_on) begin
      on_q <= avs_writedata_i[trace_buffer_pkg::CTRL_ON_BIT];
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      mask_q <= trace_buffer_pkg::MASK_BASE;
    end else if (wr_ctl && avs_byteenable_i[0]) begin
      mask_q <= avs_writedata_i[trace_buffer_pkg::CTRL_MASK_LSB +: trace_buffer_pkg::CTRL_MASK_W];
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      limit_q     <= '0;
      fill_stop_q <= 1'b0;
      fill_halt_q <= 1'b0;
    end else if (wr_fill) begin
      limit_q     <= avs_writedata_i[SRAM_AW-1:trace_buffer_pkg::FILL_ADDR_LSB];
      fill_stop_q <= avs_writedata_i[trace_buffer_pkg::FILL_STOP_BIT];
      fill_halt_q <= avs_writedata_i[trace_buffer_pkg::FILL_HALT_BIT];
    end
  end

  // Halt request holds until software clears halt_on_fill_limit
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      halt_q <= 1'b0;
    end else if (limit_hit && fill_halt_q) begin
      halt_q <= 1'b1;
    end else if (wr_fill && !avs_writedata_i[trace_buffer_pkg::FILL_HALT_BIT]) begin
      halt_q <= 1'b0;
    end
  end

  always_comb begin
    pos_word  = trace_buffer_pkg::RESET_ZERO;
    ctl_word  = trace_buffer_pkg::RESET_ZERO;
    fill_word = trace_buffer_pkg::RESET_ZERO;
    pos_word[SRAM_AW-1:trace_buffer_pkg::POS_PTR_LSB] = ptr_q;
    pos_word[trace_buffer_pkg::POS_WRAP_BIT] = wrap_q;
    ctl_word[trace_buffer_pkg::CTRL_ON_BIT] = on_q;
    ctl_word[trace_buffer_pkg::CTRL_MASK_LSB +: trace_buffer_pkg::CTRL_MASK_W] = mask_q;
    fill_word[SRAM_AW-1:trace_buffer_pkg::FILL_ADDR_LSB] = limit_q;
    fill_word[trace_buffer_pkg::FILL_STOP_BIT] = fill_stop_q;
    fill_word[trace_buffer_pkg::FILL_HALT_BIT] = fill_halt_q;
  end

  // One wait state on every access, so reads come from a flop
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      resp_q  <= 1'b0;
      rdata_q <= trace_buffer_pkg::RESET_ZERO;
    end else begin
      resp_q <= (avs_read_i | avs_write_i) & ~resp_q;
      if (avs_read_i && !resp_q) begin
        if (!sel) begin
          rdata_q <= trace_buffer_pkg::UNMAPPED_DATA;
        end else begin
          case (ofs)
            trace_buffer_pkg::OFS_POSITION:  rdata_q <= pos_word;
            trace_buffer_pkg::OFS_MAIN_CTRL: rdata_q <= ctl_word;
            trace_buffer_pkg::OFS_STOP_HALT: rdata_q <= fill_word;
            trace_buffer_pkg::OFS_SRAM_LOC:  rdata_q <= SRAM_BASE;
            default:                         rdata_q <= trace_buffer_pkg::UNMAPPED_DATA;
          endcase
        end
      end
    end
  end

  assign avs_readdata_o = rdata_q;
  assign debug_halt_o   = halt_q;
  assign trace_on_o     = on_q;

  a_no_trace_when_off: assert property (@(posedge clock_i) disable iff (srst_i)
    (pkt_q == PK_IDLE && !on_q) |=> (pkt_q == PK_IDLE)) else $error("packet started while off");

  sequence s_pkt_start;
    (pkt_q == PK_IDLE) && nonseq && on_q;
  endsequence
  sequence s_two_words;
    (sram_we_o && !sram_addr_o[2]) ##1 (sram_we_o && sram_addr_o[2]);
  endsequence
  a_packet_two_words: assert property (@(posedge clock_i) disable iff (srst_i)
    s_pkt_start |=> s_two_words ##1 !trace_wr) else $error("packet not two words");

  a_src_dst_order: assert property (@(posedge clock_i) disable iff (srst_i)
    s_pkt_start |=> (sram_wdata_o == $past(last_pc_q)) ##1 (sram_wdata_o == $past(trace_pc_i, 2)))
    else $error("packet word order wrong");

  a_branch_traced: assert property (@(posedge clock_i) disable iff (srst_i)
    (trace_valid_i && trace_branch_i && last_ok_q && on_q && pkt_q == PK_IDLE) |=> (pkt_q == PK_FIRST))
    else $error("branch not traced");

  a_trace_priority: assert property (@(posedge clock_i) disable iff (srst_i)
    trace_wr |-> (!cpu_gnt_o && sram_we_o)) else $error("cpu granted during trace write");

  a_cpu_served: assert property (@(posedge clock_i) disable iff (srst_i)
    (!trace_wr && cpu_req_i) |-> (cpu_gnt_o && sram_addr_o == cpu_addr_i)) else $error("cpu not served");

  a_fill_stop: assert property (@(posedge clock_i) disable iff (srst_i)
    (limit_hit && fill_stop_q) |=> !on_q) else $error("fill limit did not stop");

  a_wrap_flag: assert property (@(posedge clock_i) disable iff (srst_i)
    (pkt_q == PK_SECOND && wrap_now && !wr_pos) |=> (wrap_q && (ptr_q & mask_ptr) == '0))
    else $error("wrap not flagged");

  a_enable_write: assert property (@(posedge clock_i) disable iff (srst_i)
    (wr_on && !limit_hit) |=> (on_q == $past(avs_writedata_i[trace_buffer_pkg::CTRL_ON_BIT])))
    else $error("enable write ignored");

  a_halt_request: assert property (@(posedge clock_i) disable iff (srst_i)
    (limit_hit && fill_halt_q) |=> (debug_halt_o && !on_q)) else $error("halt not requested");

  a_bus_answer: assert property (@(posedge clock_i) disable iff (srst_i)
    ((avs_read_i || avs_write_i) && !resp_q) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("bus answer timing");

  a_off_stays_off: assert property (@(posedge clock_i) disable iff (srst_i)
    (!on_q && !wr_on) |=> !on_q) else $error("trace enabled without a write");

  a_wrap_sticky: assert property (@(posedge clock_i) disable iff (srst_i)
    (wrap_q && !wr_pos) |=> wrap_q) else $error("wrap flag lost");

  a_halt_hold: assert property (@(posedge clock_i) disable iff (srst_i)
    (debug_halt_o && !wr_fill) |=> debug_halt_o) else $error("halt request dropped");

  a_fixed_ptr_bits: assert property (@(posedge clock_i) disable iff (srst_i)
    (pkt_q == PK_SECOND && !wr_pos) |=> (((ptr_q ^ $past(ptr_q)) & ~$past(mask_ptr)) == '0))
    else $error("pointer left the buffer");

  a_ptr_held_idle: assert property (@(posedge clock_i) disable iff (srst_i)
    (pkt_q != PK_SECOND && !wr_pos) |=> $stable(ptr_q)) else $error("pointer moved without a packet");

  a_write_on_answer: assert property (@(posedge clock_i) disable iff (srst_i)
    (wr_pos || wr_ctl || wr_fill) |-> (!avs_waitrequest_o && resp_q))
    else $error("register written before answer");

endmodule

// file: bench/trace_sram_model.sv
`timescale 1ns/1ps
module trace_sram_model #(
  parameter int AW = 12
) (
  input  wire logic          clock_i,
  input  wire logic          req_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [31:0]   wdata_i,
  input  wire logic [3:0]    be_i,
  output logic      [31:0]   rdata_o
);
  // Open to the bench as the debugger's view of the recorded trace
  logic [31:0] mem [0:(2**(AW-2))-1];
  always_ff @(posedge clock_i) begin
    for (int b = 0; b < 4; b++) begin
      if (req_i && we_i && be_i[b]) begin
        mem[addr_i[AW-1:2]][8*b +: 8] <= wdata_i[8*b +: 8];
      end
    end
  end
  // Idle read lines show the inverted word so stale data never passes
  assign rdata_o = (req_i && !we_i) ? mem[addr_i[AW-1:2]] : ~mem[addr_i[AW-1:2]];
endmodule

// file: bench/execution_trace_buffer_bench.sv
`timescale 1ns/1ps
module execution_trace_buffer_bench;
  localparam logic [31:0] B = trace_buffer_pkg::REG_BASE_ADDR;
  logic        clock_i = 1'b0;
  logic        srst_i  = 1'b1;
  logic [31:0] a_addr  = 32'h00000000;
  logic [31:0] a_wd    = 32'h00000000;
  logic [31:0] pc      = 32'h00000000;
  logic [31:0] cwd     = 32'h00000000;
  logic [31:0] q;
  logic [31:0] rd_q, cpu_rd, s_wd, s_rd;
  logic [11:0] caddr   = 12'h000;
  logic [11:0] s_addr;
  logic [3:0]  s_be;
  logic        a_rd = 1'b0, a_wr = 1'b0, tv = 1'b0, tb = 1'b0, te = 1'b0, creq = 1'b0, cwe = 1'b0;
  logic        wait_o, gnt, s_req, s_we, halt, ton;
  int          error_cnt = 0;
  int          n_checks  = 0;
  logic [31:0] exp_t [5] = '{32'h00000000, 32'h00000004, 32'h00000000,
                             trace_buffer_pkg::SRAM_BASE_DFLT, trace_buffer_pkg::UNMAPPED_DATA};

  initial forever #10 clock_i = ~clock_i;

  execution_trace_buffer dut_u (
    .clock_i(clock_i), .srst_i(srst_i), .avs_address_i(a_addr), .avs_read_i(a_rd), .avs_write_i(a_wr),
    .avs_byteenable_i(4'hf), .avs_writedata_i(a_wd), .avs_readdata_o(rd_q), .avs_waitrequest_o(wait_o),
    .trace_valid_i(tv), .trace_pc_i(pc), .trace_branch_i(tb), .trace_exception_i(te),
    .cpu_req_i(creq), .cpu_we_i(cwe), .cpu_addr_i(caddr), .cpu_wdata_i(cwd), .cpu_be_i(4'hf),
    .cpu_gnt_o(gnt), .cpu_rdata_o(cpu_rd), .sram_req_o(s_req), .sram_we_o(s_we), .sram_addr_o(s_addr),
    .sram_wdata_o(s_wd), .sram_be_o(s_be), .sram_rdata_i(s_rd), .debug_halt_o(halt), .trace_on_o(ton));

  trace_sram_model #(.AW(12)) sram_u (
    .clock_i(clock_i), .req_i(s_req), .we_i(s_we), .addr_i(s_addr), .wdata_i(s_wd), .be_i(s_be),
    .rdata_o(s_rd));

  task automatic end_sim;
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // The request stands until waitrequest is seen low at a rising edge; data is taken there
  task automatic bus(input logic w, input logic [31:0] addr, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clock_i);
    a_addr <= addr;
    a_wd   <= d;
    a_rd   <= !w;
    a_wr   <= w;
    @(posedge clock_i);
    while (wait_o !== 1'b0) begin
      n++;
      if (n > 20) begin
        error_cnt++;
        end_sim();
      end
      @(posedge clock_i);
    end
    r = rd_q;
    a_rd <= 1'b0;
    a_wr <= 1'b0;
    @(posedge clock_i);
  endtask

  // The processor keeps a read pending, so a packet must take the port from it
  task automatic tr(input logic [31:0] p, input logic br, input logic ex, input logic pk);
    @(posedge clock_i);
    tv <= 1'b1;
    pc <= p;
    tb <= br;
    te <= ex;
    @(posedge clock_i);
    tv <= 1'b0;
    tb <= 1'b0;
    te <= 1'b0;
    #1;
    chk("sram_we", {31'h0, pk}, {31'h0, s_we});
    chk("cpu_gnt", {31'h0, !pk}, {31'h0, gnt});
    repeat (3) @(posedge clock_i);
  endtask

  initial begin
    repeat (20) @(posedge clock_i);
    srst_i <= 1'b0;
    creq   <= 1'b1;
    bus(1'b1, B + 32'h0000000c, 32'hffffffff, q);
    bus(1'b1, B + 32'h00000010, 32'hffffffff, q);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, B + 32'(4 * i), 32'h00000000, q);
      chk("reg", exp_t[i], q);
    end
    tr(32'h00000100, 1'b0, 1'b0, 1'b0);
    tr(32'h000000fc, 1'b1, 1'b0, 1'b0);
    bus(1'b1, B + 32'h00000004, 32'h80000000, q);
    chk("trace_on", 32'h1, {31'h0, ton});
    tr(32'h00000100, 1'b0, 1'b0, 1'b0);
    tr(32'h00000102, 1'b0, 1'b0, 1'b0);
    tr(32'h00000200, 1'b1, 1'b0, 1'b1);
    chk("word0", 32'h00000102, sram_u.mem[0]);
    chk("word1", 32'h00000200, sram_u.mem[1]);
    bus(1'b0, B, 32'h00000000, q);
    chk("position", 32'h00000008, q);
    tr(32'h00000300, 1'b0, 1'b0, 1'b1);
    bus(1'b0, B, 32'h00000000, q);
    chk("position", 32'h00000004, q);
    tr(32'h00000304, 1'b0, 1'b1, 1'b1);
    chk("word0", 32'h00000300, sram_u.mem[0]);
    chk("word1", 32'h00000304, sram_u.mem[1]);
    bus(1'b1, B + 32'h00000004, 32'h00000000, q);
    chk("trace_on", 32'h0, {31'h0, ton});
    tr(32'h00000500, 1'b1, 1'b0, 1'b0);
    bus(1'b1, B, 32'h00000010, q);
    bus(1'b1, B + 32'h00000008, 32'h0000001b, q);
    bus(1'b0, B + 32'h00000008, 32'h00000000, q);
    chk("stop_halt", 32'h0000001b, q);
    bus(1'b1, B + 32'h00000004, 32'h80000001, q);
    tr(32'h00000700, 1'b1, 1'b0, 1'b1);
    chk("word0", 32'h00000500, sram_u.mem[4]);
    chk("word1", 32'h00000700, sram_u.mem[5]);
    chk("trace_on", 32'h0, {31'h0, ton});
    chk("halt", 32'h1, {31'h0, halt});
    tr(32'h00000800, 1'b1, 1'b0, 1'b0);
    bus(1'b1, B + 32'h00000008, 32'h00000000, q);
    chk("halt", 32'h0, {31'h0, halt});
    @(posedge clock_i);
    cwe   <= 1'b1;
    caddr <= 12'h100;
    cwd   <= 32'h5a5aa5a5;
    @(posedge clock_i);
    cwe <= 1'b0;
    #1;
    chk("cpu_rdata", 32'h5a5aa5a5, cpu_rd);
    end_sim();
  end

  initial begin
    #1000000;
    error_cnt++;
    end_sim();
  end
endmodule
